// ### rtl/tss_synth.sv
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tss_synth (
  input  wire logic                          I_CLK,
  input  wire logic                          I_SYS_RST,
  input  wire logic                          I_HSEL,
  input  wire logic [31:0]                   I_HADDR,
  input  wire logic [1:0]                    I_HTRANS,
  input  wire logic                          I_HWRITE,
  input  wire logic [2:0]                    I_HSIZE,
  input  wire logic [31:0]                   I_HWDATA,
  input  wire logic                          I_HREADY,
  output logic      [31:0]                   O_HRDATA,
  output logic                               O_HREADYOUT,
  output logic                               O_HRESP,
  input  wire logic                          I_HALF_SINE,
  input  wire logic [tss_pkg::WORD_W-1:0]    I_ADC_RATE,
  output tss_pkg::tss_drive_type             O_DRIVE,
  output logic                               O_STEP_PULSE,
  output logic      [tss_pkg::WORD_W-1:0]    O_CMD_WORD,
  output logic      [tss_pkg::WORD_W-1:0]    O_LOOP_REF
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                         wr_pend_reg;
  logic [tss_pkg::REG_AW-1:0]   wr_addr_reg;
  logic [31:0]                  hrdata_reg;
  logic                         addr_ok;
  logic                         wr_en;
  logic [tss_pkg::WORD_W-1:0]   wdata;
  logic [31:0]                  rdata_next;
  tss_pkg::tss_status_type      status;
  logic                         ramp_en_reg;
  logic                         mode_analog_reg;
  logic                         load_reg;
  logic [tss_pkg::WORD_W-1:0]   pps_reg;
  logic [tss_pkg::WORD_W-1:0]   start_reg;
  logic [tss_pkg::WORD_W-1:0]   target_reg;
  logic [tss_pkg::WORD_W-1:0]   rate_reg;
  logic [tss_pkg::WORD_W-1:0]   cmd_reg;
  logic [tss_pkg::WORD_W-1:0]   ref_reg;
  logic                         sine_q_reg;
  logic                         pulse_edge;
  logic [tss_pkg::WORD_W-1:0]   pulse_cnt_reg;
  logic [tss_pkg::WORD_W:0]     cnt_inc;
  logic [tss_pkg::WORD_W-1:0]   active_pps;
  logic                         hit;
  logic                         step_pulse_reg;
  tss_pkg::tss_step_type        step_reg;
  tss_pkg::tss_drive_type       drive_reg;
  tss_pkg::tss_drive_type       drive_next;
  logic [tss_pkg::UNIT_W-1:0]   unit_cnt_reg;
  logic                         unit_tick;
  logic [tss_pkg::WORD_W-1:0]   rate_cnt_reg;
  logic [tss_pkg::WORD_W-1:0]   rate_sel;
  logic                         ramp_tick;
  logic [tss_pkg::WORD_W-1:0]   ramp_reg;
  logic                         dir_up_reg;
  logic                         ramp_done;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // address phase accepted when selected, active and bus ready
  assign addr_ok = I_HSEL && I_HTRANS[tss_pkg::HTRANS_SEQ_BIT] && I_HREADY;
  assign wr_en   = wr_pend_reg;
  assign wdata   = I_HWDATA[tss_pkg::WORD_W-1:0];

  // capture write address for the following data phase
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= addr_ok && I_HWRITE;
      if (addr_ok) begin
        wr_addr_reg <= I_HADDR[tss_pkg::REG_AW-1:0];
      end
    end
  end

  // status word assembly
  always_comb begin
    status           = '0;
    status.dir_up    = dir_up_reg;
    status.ramp_done = ramp_done;
    status.active    = active_pps;
    status.ramp      = ramp_reg;
    status.step      = step_reg;
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata_next = tss_pkg::DATA_ZERO;
    unique case (I_HADDR[tss_pkg::REG_AW-1:0])
      tss_pkg::OFS_CTRL: begin
        rdata_next[tss_pkg::CTRL_RAMP_BIT] = ramp_en_reg;
        rdata_next[tss_pkg::CTRL_MODE_BIT] = mode_analog_reg;
      end
      tss_pkg::OFS_PPS:    rdata_next[tss_pkg::WORD_W-1:0] = pps_reg;
      tss_pkg::OFS_START:  rdata_next[tss_pkg::WORD_W-1:0] = start_reg;
      tss_pkg::OFS_TARGET: rdata_next[tss_pkg::WORD_W-1:0] = target_reg;
      tss_pkg::OFS_RATE:   rdata_next[tss_pkg::WORD_W-1:0] = rate_reg;
      tss_pkg::OFS_CMD:    rdata_next[tss_pkg::WORD_W-1:0] = cmd_reg;
      tss_pkg::OFS_REF:    rdata_next[tss_pkg::WORD_W-1:0] = ref_reg;
      tss_pkg::OFS_STATUS: rdata_next = status;
      default:             rdata_next = tss_pkg::DATA_ZERO;
    endcase
  end

  // read data registered into the data phase
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      hrdata_reg <= tss_pkg::DATA_ZERO;
    end else if (addr_ok && !I_HWRITE) begin
      hrdata_reg <= rdata_next;
    end
  end

  assign O_HRDATA    = hrdata_reg;
  assign O_HREADYOUT = 1'b1;  // zero wait states
  assign O_HRESP     = 1'b0;  // always okay

  // ----------------------------------------------------------------
  // command latches
  // ----------------------------------------------------------------
  // control bits, load is a self-clearing strobe
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ramp_en_reg     <= 1'b0;
      mode_analog_reg <= 1'b0;
      load_reg        <= 1'b0;
    end else begin
      load_reg <= 1'b0;
      if (wr_en && wr_addr_reg == tss_pkg::OFS_CTRL) begin
        ramp_en_reg     <= wdata[tss_pkg::CTRL_RAMP_BIT];
        mode_analog_reg <= wdata[tss_pkg::CTRL_MODE_BIT];
        load_reg        <= wdata[tss_pkg::CTRL_LOAD_BIT];
      end
    end
  end

  // value latches, captured on the write strobe
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pps_reg    <= tss_pkg::PPS_RST;
      start_reg  <= tss_pkg::WORD_RST;
      target_reg <= tss_pkg::WORD_RST;
      rate_reg   <= tss_pkg::WORD_RST;
      cmd_reg    <= tss_pkg::WORD_RST;
      ref_reg    <= tss_pkg::WORD_RST;
    end else if (wr_en) begin
      unique case (wr_addr_reg)
        tss_pkg::OFS_PPS:    pps_reg    <= wdata;
        tss_pkg::OFS_START:  start_reg  <= wdata;
        tss_pkg::OFS_TARGET: target_reg <= wdata;
        tss_pkg::OFS_RATE:   rate_reg   <= wdata;
        tss_pkg::OFS_CMD:    cmd_reg    <= wdata;
        tss_pkg::OFS_REF:    ref_reg    <= wdata;
        default: ;
      endcase
    end
  end

  assign O_CMD_WORD = cmd_reg;
  assign O_LOOP_REF = ref_reg;  // ladder converter input

  // ----------------------------------------------------------------
  // pulse count-up
  // ----------------------------------------------------------------
  // rising edge of the half-sine pulse input
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      sine_q_reg <= 1'b0;
    end else begin
      sine_q_reg <= I_HALF_SINE;
    end
  end
  assign pulse_edge = I_HALF_SINE && !sine_q_reg;

  // active setting: ramp value or direct word
  assign active_pps = ramp_en_reg ? ramp_reg : pps_reg;
  assign cnt_inc    = {1'b0, pulse_cnt_reg} + {1'b0, tss_pkg::WORD_ONE};
  // zero setting holds the sequencer; n pulses per step sets frequency
  assign hit = pulse_edge && (active_pps != tss_pkg::WORD_RST) && (cnt_inc >= {1'b0, active_pps});

  // comparison counter with reset on match
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pulse_cnt_reg  <= tss_pkg::WORD_RST;
      step_pulse_reg <= 1'b0;
    end else begin
      step_pulse_reg <= hit;  // one cycle wide
      if (wr_en && wr_addr_reg == tss_pkg::OFS_PPS) begin
        pulse_cnt_reg <= tss_pkg::WORD_RST;  // strobe clears counter
      end else if (hit) begin
        pulse_cnt_reg <= tss_pkg::WORD_RST;
      end else if (pulse_edge) begin
        pulse_cnt_reg <= cnt_inc[tss_pkg::WORD_W-1:0];
      end
    end
  end
  assign O_STEP_PULSE = step_pulse_reg;

  // ----------------------------------------------------------------
  // steering sequencer
  // ----------------------------------------------------------------
  function automatic tss_pkg::tss_step_type seq_next(input tss_pkg::tss_step_type s);
    unique case (s)
      tss_pkg::STEP_00: seq_next = tss_pkg::STEP_01;
      tss_pkg::STEP_01: seq_next = tss_pkg::STEP_02;
      tss_pkg::STEP_02: seq_next = tss_pkg::STEP_03;
      tss_pkg::STEP_03: seq_next = tss_pkg::STEP_04;
      tss_pkg::STEP_04: seq_next = tss_pkg::STEP_05;
      tss_pkg::STEP_05: seq_next = tss_pkg::STEP_06;
      tss_pkg::STEP_06: seq_next = tss_pkg::STEP_07;
      tss_pkg::STEP_07: seq_next = tss_pkg::STEP_08;
      tss_pkg::STEP_08: seq_next = tss_pkg::STEP_09;
      tss_pkg::STEP_09: seq_next = tss_pkg::STEP_10;
      tss_pkg::STEP_10: seq_next = tss_pkg::STEP_11;
      default:          seq_next = tss_pkg::STEP_00;
    endcase
  endfunction

  // twelve-state ring, one state per step pulse
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      step_reg <= tss_pkg::STEP_00;
    end else if (step_pulse_reg) begin
      step_reg <= seq_next(step_reg);
    end
  end

  // 30 degree segments, connect and open phases in rotation
  always_comb begin
    unique case (step_reg)
      tss_pkg::STEP_00: drive_next = '{pos: tss_pkg::PH_B, ret: tss_pkg::PH_C};
      tss_pkg::STEP_01: drive_next = '{pos: tss_pkg::PH_A | tss_pkg::PH_B, ret: tss_pkg::PH_C};
      tss_pkg::STEP_02: drive_next = '{pos: tss_pkg::PH_A, ret: tss_pkg::PH_C};
      tss_pkg::STEP_03: drive_next = '{pos: tss_pkg::PH_A, ret: tss_pkg::PH_B | tss_pkg::PH_C};
      tss_pkg::STEP_04: drive_next = '{pos: tss_pkg::PH_A, ret: tss_pkg::PH_B};
      tss_pkg::STEP_05: drive_next = '{pos: tss_pkg::PH_A | tss_pkg::PH_C, ret: tss_pkg::PH_B};
      tss_pkg::STEP_06: drive_next = '{pos: tss_pkg::PH_C, ret: tss_pkg::PH_B};
      tss_pkg::STEP_07: drive_next = '{pos: tss_pkg::PH_C, ret: tss_pkg::PH_A | tss_pkg::PH_B};
      tss_pkg::STEP_08: drive_next = '{pos: tss_pkg::PH_C, ret: tss_pkg::PH_A};
      tss_pkg::STEP_09: drive_next = '{pos: tss_pkg::PH_B | tss_pkg::PH_C, ret: tss_pkg::PH_A};
      tss_pkg::STEP_10: drive_next = '{pos: tss_pkg::PH_B, ret: tss_pkg::PH_A};
      tss_pkg::STEP_11: drive_next = '{pos: tss_pkg::PH_B, ret: tss_pkg::PH_A | tss_pkg::PH_C};
      default:          drive_next = '{pos: tss_pkg::PH_B, ret: tss_pkg::PH_C};
    endcase
  end

  // registered drive outputs
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      drive_reg <= '{pos: tss_pkg::PH_B, ret: tss_pkg::PH_C};
    end else begin
      drive_reg <= drive_next;
    end
  end
  assign O_DRIVE = drive_reg;

  // ----------------------------------------------------------------
  // rate clock
  // ----------------------------------------------------------------
  // source select: register word or converted analog
  assign rate_sel  = mode_analog_reg ? I_ADC_RATE : rate_reg;
  assign unit_tick = unit_cnt_reg == tss_pkg::UNIT_LAST;  // one pulse period
  assign ramp_tick = unit_tick && (rate_cnt_reg == rate_sel);

  // divider: (rate+1) pulse periods per ramp tick
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || load_reg) begin
      unit_cnt_reg <= '0;
      rate_cnt_reg <= tss_pkg::WORD_RST;
    end else begin
      unit_cnt_reg <= unit_tick ? '0 : unit_cnt_reg + 1'b1;
      if (ramp_tick) begin
        rate_cnt_reg <= tss_pkg::WORD_RST;
      end else if (unit_tick) begin
        rate_cnt_reg <= rate_cnt_reg + tss_pkg::WORD_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // frequency change counter
  // ----------------------------------------------------------------
  // stop once target reached or passed
  assign ramp_done = dir_up_reg ? (ramp_reg >= target_reg) : (ramp_reg <= target_reg);

  // preset load, then step toward target
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ramp_reg   <= tss_pkg::WORD_RST;
      dir_up_reg <= 1'b0;
    end else if (load_reg) begin
      ramp_reg   <= start_reg;
      dir_up_reg <= target_reg > start_reg;
    end else if (ramp_tick && !ramp_done) begin
      ramp_reg <= dir_up_reg ? ramp_reg + tss_pkg::WORD_ONE : ramp_reg - tss_pkg::WORD_ONE;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  sequence s_pulse_hit;
    pulse_edge && hit;
  endsequence
  sequence s_step_taken;
    step_pulse_reg && pulse_cnt_reg == tss_pkg::WORD_RST;
  endsequence

  property p_seq_adv;
    step_pulse_reg |=> step_reg == seq_next($past(step_reg));
  endproperty
  a_seq_adv: assert property (p_seq_adv) else $error("sequencer did not advance");
  property p_seq_hold;
    !step_pulse_reg |=> $stable(step_reg);
  endproperty
  a_seq_hold: assert property (p_seq_hold) else $error("sequencer moved without step");
  property p_drive_legal;
    ((O_DRIVE.pos & O_DRIVE.ret) == 3'h0) && ($countones({O_DRIVE.pos, O_DRIVE.ret}) == 3
      || $countones({O_DRIVE.pos, O_DRIVE.ret}) == 2);
  endproperty
  a_drive_legal: assert property (p_drive_legal) else $error("illegal phase drive");
  property p_cnt_inc;
    pulse_edge && !hit && !wr_en |=> pulse_cnt_reg == $past(pulse_cnt_reg) + tss_pkg::WORD_ONE;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("pulse count not incremented");
  property p_eq_step;
    s_pulse_hit |=> s_step_taken;
  endproperty
  a_eq_step: assert property (p_eq_step) else $error("match did not step");
  property p_pps_load;
    wr_en && wr_addr_reg == tss_pkg::OFS_PPS |=> pps_reg == $past(wdata);
  endproperty
  a_pps_load: assert property (p_pps_load) else $error("step word not captured");
  property p_preset;
    load_reg |=> ramp_reg == $past(start_reg);
  endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");
  property p_dir;
    ramp_tick && !ramp_done && !load_reg |=>
      ramp_reg == ($past(dir_up_reg) ? $past(ramp_reg) + tss_pkg::WORD_ONE : $past(ramp_reg) - tss_pkg::WORD_ONE);
  endproperty
  a_dir: assert property (p_dir) else $error("ramp stepped wrong way");
  property p_active;
    ramp_en_reg && pulse_edge && ramp_reg != tss_pkg::WORD_RST
      && pulse_cnt_reg + tss_pkg::WORD_ONE == ramp_reg |=> step_pulse_reg;
  endproperty
  a_active: assert property (p_active) else $error("ramp value did not set the step count");
  property p_stop;
    ramp_done && !load_reg |=> $stable(ramp_reg);
  endproperty
  a_stop: assert property (p_stop) else $error("ramp moved past target");
  property p_one_cycle;
    step_pulse_reg |=> !step_pulse_reg;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("step pulse longer than one cycle");

endmodule // tss_synth

// ### rtl/tss_pkg.sv
// Notes on behaviour
// - sequencer walks twelve states in a ring, one state per step pulse
// - each state is a 30 degree segment rotating positive and return phases
// - pulse counter adds one on each half-sine bus pulse
// - count reaching pulses-per-step clears counter and fires one step pulse
// - pulses-per-step word is captured when the outside party strobes it
// - one pulse per step gives top frequency; more pulses lower it
// - a load copies the starting value into the up/down ramp counter
// - target value stays held as the ramp comparator reference
// - ramp counts up when target exceeds start, down when below
// - ramp counter value is the active pulses-per-step setting
// - ramp is stepped by a rate clock, digital or converted analog source
// - command words are eight bits wide, width kept as one constant
// - general command word is latched on an outside supplied strobe
// - loop reference word is latched and drives the ladder converter
// - each counted bus pulse lasts 25 us, the time base of a step
package tss_pkg;

  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int WORD_W        = 8;
  localparam int REG_AW        = 8;
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_TIME_NS = 25000;  // half-sine pulse length
  localparam int PULSE_CYCLES  = PULSE_TIME_NS / CLK_PERIOD_NS;
  localparam int UNIT_W        = 10;
  localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(PULSE_CYCLES - 1);

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [REG_AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [REG_AW-1:0] OFS_PPS    = 8'h04;
  localparam logic [REG_AW-1:0] OFS_START  = 8'h08;
  localparam logic [REG_AW-1:0] OFS_TARGET = 8'h0C;
  localparam logic [REG_AW-1:0] OFS_RATE   = 8'h10;
  localparam logic [REG_AW-1:0] OFS_CMD    = 8'h14;
  localparam logic [REG_AW-1:0] OFS_REF    = 8'h18;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h1C;

  // control fields and reset values
  localparam int CTRL_RAMP_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_LOAD_BIT = 2;
  localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
  localparam logic [WORD_W-1:0] PPS_RST  = 8'h01;
  localparam logic [WORD_W-1:0] WORD_ONE = 8'h01;

  // ----------------------------------------------------------------
  // bus constants
  // ----------------------------------------------------------------
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  localparam int          HTRANS_SEQ_BIT = 1;

  // phase masks, order {A, B, C}
  localparam logic [2:0] PH_A = 3'h4;
  localparam logic [2:0] PH_B = 3'h2;
  localparam logic [2:0] PH_C = 3'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    STEP_00, STEP_01, STEP_02, STEP_03, STEP_04, STEP_05,
    STEP_06, STEP_07, STEP_08, STEP_09, STEP_10, STEP_11
  } tss_step_type;

  typedef struct packed {
    logic [2:0] pos;
    logic [2:0] ret;
  } tss_drive_type;

  typedef struct packed {
    logic [5:0]        rsvd;
    logic              dir_up;
    logic              ramp_done;
    logic [WORD_W-1:0] active;
    logic [WORD_W-1:0] ramp;
    logic [3:0]        pad;
    logic [3:0]        step;
  } tss_status_type;

endpackage

// ### tb/tss_bridge_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// half-sine bus source and bridge short watch
// ----------------------------------------------------------------
module tss_bridge_model #(
  parameter int HI_CYCLES = 1000,  // half-sine pulse length
  parameter int LO_CYCLES = 2      // low gap so each pulse has its own rising edge
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_fire,
  input  wire tss_pkg::tss_drive_type i_drive,
  output logic                        o_half_sine,
  output logic                        o_busy,
  output logic                        o_short
);
  int cnt_reg;

  // one pulse per request, then a forced low gap
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg     <= 0;
      o_half_sine <= 1'b0;
    end else if (cnt_reg == 0) begin
      if (i_fire) begin
        cnt_reg     <= HI_CYCLES + LO_CYCLES;
        o_half_sine <= 1'b1;
      end
    end else begin
      cnt_reg <= cnt_reg - 1;
      if (cnt_reg == LO_CYCLES + 1) begin
        o_half_sine <= 1'b0;
      end
    end
  end

  // a phase on both rails would short the bridge
  assign o_short = |(i_drive.pos & i_drive.ret);
  assign o_busy  = (cnt_reg != 0);
endmodule // tss_bridge_model

// ### tb/tss_synth_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
module tss_synth_tb;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
  } tss_row_type;

  // register rows: address, written word, expected read back
  localparam tss_row_type ROWS [6] = '{
    '{8'h14, 32'h0000_01A5, 32'h0000_00A5}, '{8'h18, 32'h0000_005A, 32'h0000_005A},
    '{8'h08, 32'hFFFF_FF03, 32'h0000_0003}, '{8'h0C, 32'h0000_0005, 32'h0000_0005},
    '{8'h10, 32'h0000_0000, 32'h0000_0000}, '{8'h20, 32'h0000_00FF, 32'h0000_0000}};
  // expected {pos, ret} per sequencer state
  localparam logic [5:0] SEQ [12] = '{6'h11, 6'h31, 6'h21, 6'h23, 6'h22, 6'h2A,
                                      6'h0A, 6'h0E, 6'h0C, 6'h1C, 6'h14, 6'h15};

  logic                   clk    = 1'b0;
  logic                   rst    = 1'b1;
  logic                   hsel   = 1'b0;
  logic [31:0]            haddr  = 32'h0000_0000;
  logic [1:0]             htrans = 2'h0;
  logic                   hwrite = 1'b0;
  logic [31:0]            hwdata = 32'h0000_0000;
  logic [7:0]             adc    = 8'h00;
  logic                   fire   = 1'b0;
  logic                   hready;
  logic                   hresp;
  logic [31:0]            rdata;
  logic                   half_sine;
  logic                   busy;
  logic                   shorted;
  logic                   stp;
  logic [7:0]             cmd;
  logic [7:0]             lref;
  tss_pkg::tss_drive_type drive;
  logic [31:0]            q;
  int                     miscompares = 0;
  int                     tests_run   = 0;
  int                     steps       = 0;
  int                     shorts      = 0;

  always #12.5 clk = ~clk;

  tss_synth dut (
    .I_CLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(rdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_HALF_SINE(half_sine),
    .I_ADC_RATE(adc), .O_DRIVE(drive), .O_STEP_PULSE(stp), .O_CMD_WORD(cmd), .O_LOOP_REF(lref));

  tss_bridge_model #(.HI_CYCLES(2), .LO_CYCLES(2)) bridge (
    .i_clk(clk), .i_rst(rst), .i_fire(fire), .i_drive(drive),
    .o_half_sine(half_sine), .o_busy(busy), .o_short(shorted));

  // step pulse cycles and bridge shorts seen
  always @(posedge clk) begin
    if (stp === 1'b1) steps++;
    if (shorted === 1'b1) shorts++;
  end

  task automatic give_verdict;
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = rdata;
  endtask

  // one half-sine pulse, then time for the step to reach the drive
  task automatic pulse;
    while (busy === 1'b1) @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(drive, SEQ[0])
    `CHK(cmd, 8'h00)
    bus(1'b0, 8'h04, 32'h0, q);
    `CHK(q, 32'h0000_0001)
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict;
  end

  initial begin
    do_reset;
    // register table rows
    foreach (ROWS[i]) begin
      bus(1'b1, ROWS[i].a, ROWS[i].d, q);
      bus(1'b0, ROWS[i].a, 32'h0, q);
      `CHK(q, ROWS[i].q)
    end
    `CHK(cmd, 8'hA5)
    `CHK(lref, 8'h5A)
    // one full electrical cycle at one pulse per step
    for (int i = 1; i <= 12; i++) begin
      pulse;
      `CHK(drive, SEQ[i % 12])
      bus(1'b0, 8'h1C, 32'h0, q);
      `CHK(q[3:0], 4'(i % 12))
    end
    `CHK(steps, 12)
    // three pulses per step: only the third advances
    bus(1'b1, 8'h04, 32'h0000_0003, q);
    pulse;
    pulse;
    `CHK(drive, SEQ[0])
    pulse;
    `CHK(drive, SEQ[1])
    bus(1'b1, 8'h04, 32'h0000_0000, q);
    pulse;
    `CHK(drive, SEQ[1])
    // upward ramp 3 to 5, digital rate 0
    bus(1'b1, 8'h00, 32'h0000_0005, q);
    repeat (5) @(posedge clk);
    bus(1'b0, 8'h1C, 32'h0, q);
    `CHK(q[25:8], {2'b10, 8'h03, 8'h03})
    repeat (2100) @(posedge clk);
    bus(1'b0, 8'h1C, 32'h0, q);
    `CHK(q[25:8], {2'b11, 8'h05, 8'h05})
    repeat (1100) @(posedge clk);
    bus(1'b0, 8'h1C, 32'h0, q);
    `CHK(q[25:8], {2'b11, 8'h05, 8'h05})
    // downward ramp 5 to 3
    bus(1'b1, 8'h08, 32'h0000_0005, q);
    bus(1'b1, 8'h0C, 32'h0000_0003, q);
    bus(1'b1, 8'h00, 32'h0000_0005, q);
    repeat (5) @(posedge clk);
    bus(1'b0, 8'h1C, 32'h0, q);
    `CHK(q[25:8], {2'b00, 8'h05, 8'h05})
    repeat (2100) @(posedge clk);
    bus(1'b0, 8'h1C, 32'h0, q);
    `CHK(q[25:8], {2'b01, 8'h03, 8'h03})
    // ramp value of 3 now sets pulses per step
    bus(1'b1, 8'h04, 32'h0000_0000, q);
    pulse;
    pulse;
    `CHK(drive, SEQ[1])
    pulse;
    `CHK(drive, SEQ[2])
    // analog rate source, tick every 2000 cycles
    adc <= 8'h01;
    bus(1'b1, 8'h08, 32'h0000_0002, q);
    bus(1'b1, 8'h00, 32'h0000_0007, q);
    repeat (1500) @(posedge clk);
    bus(1'b0, 8'h1C, 32'h0, q);
    `CHK(q[15:8], 8'h02)
    repeat (700) @(posedge clk);
    bus(1'b0, 8'h1C, 32'h0, q);
    `CHK(q[15:8], 8'h03)
    `CHK(shorts, 0)
    `CHK(hresp, 1'b0)
    // second reset in mid-run
    do_reset;
    give_verdict;
  end
endmodule // tss_synth_tb
